// ### src/hosw_defs.vh
`ifndef HOSW_DEFS_VH
`define HOSW_DEFS_VH

// register offsets
`define HOSW_ADDR_BAL_SEL 8'h84
`define HOSW_ADDR_CTRL 8'h85
`define HOSW_ADDR_STATUS 8'h86
`define HOSW_ADDR_LIMITS 8'h87

// control register fields
`define HOSW_CTRL_CASCADE 0
`define HOSW_CTRL_BAL_OVR 1
`define HOSW_CTRL_SCAN_OVR 2
`define HOSW_CTRL_CMON_OVR 3
`define HOSW_CTRL_LMON_OVR 4
`define HOSW_CTRL_SW_OVR 5
`define HOSW_CTRL_NV_EN 6
`define HOSW_CTRL_BAL_EN 7
`define HOSW_CTRL_CLR_MASK 8'h7C
`define HOSW_CTRL_ACT_MASK 8'h7E

// limits register fields
`define HOSW_LIM_MISMATCH_EN 0
`define HOSW_LIM_OPEN_EN 1

// reset values
`define HOSW_BAL_SEL_RST 8'h00
`define HOSW_CTRL_RST 8'h00
`define HOSW_LIM_RST 8'h00

// timing
`define HOSW_CLK_MHZ 200
`define HOSW_OFF_PULSE_US 300
`define HOSW_OFF_PULSE_CYC (`HOSW_OFF_PULSE_US * `HOSW_CLK_MHZ)
`define HOSW_ALERT_PERIOD_MS 1000
`define HOSW_ALERT_PERIOD_CYC (`HOSW_ALERT_PERIOD_MS * 1000 * `HOSW_CLK_MHZ)
`define HOSW_WDOG_MS 1000
`define HOSW_WDOG_CYC (`HOSW_WDOG_MS * 1000 * `HOSW_CLK_MHZ)
`define HOSW_ALERT_WIDTH_CYC 200

// slave address bases (address select pin picks the low bit)
`define HOSW_SLAVE_ADDR_BASE 7'h28

`endif

// ### src/hosw_host_override_watchdog.v
`timescale 1ns/100ps
`include "hosw_defs.vh"

// Overview of operation
// - address select high means bottom device: no current monitor, switches off.
// - cascade enable drops current detection from the balancing decision.
// - cascade enable leaves scanning and protection running normally.
// - select register at 84H maps each bit to one balance output.
// - with balance override set, balance output enable drives the selected pattern onto the outputs.
// - watchdog idle standalone; armed by any host override or nonvolatile enable bit.
// - armed watchdog times out after a full period without bus traffic.
// - only start plus matching slave address restarts the watchdog.
// - timeout forces balance and power switches off and resets serial logic.
// - after timeout alert pulses low once per second until traffic resumes.
// - while timed out other operation continues, switches held off.
// - on resume clear override bits except balance override; switches may return.
// - switch turn-off pull-down pulse lasts at most 300 us.
// - fault output low while any failure exists, released when all clear.
// - end-of-charge low when all cells above threshold, high when all below.
// - fuse-blow high when any cell reaches the overvoltage lockout threshold.
// - fuse-blow optionally high on cell mismatch or open wire.
// - force-off input high turns off power and balance switches above all.
// - nonvolatile access only with enable set, else shadow storage.
module hosw_host_override_watchdog #(
    parameter WDOG_CYC = `HOSW_WDOG_CYC,
    parameter ALERT_PERIOD_CYC = `HOSW_ALERT_PERIOD_CYC,
    parameter ALERT_WIDTH_CYC = `HOSW_ALERT_WIDTH_CYC,
    parameter OFF_PULSE_CYC = `HOSW_OFF_PULSE_CYC,
    parameter CELLS = 8
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    input wire ce,
    // serial bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire addr_sel,
    // automatic and host control requests
    input wire [CELLS-1:0] auto_balance,
    input wire current_detected,
    input wire balance_conditions_ok,
    input wire [2:0] auto_switch_on,
    input wire [2:0] host_switch_on,
    // protection inputs
    input wire any_failure,
    input wire all_cells_above_eoc,
    input wire all_cells_below_eoc,
    input wire overvoltage_lockout,
    input wire cell_mismatch_fault,
    input wire open_wire_fault,
    input wire force_switches_off,
    // outputs to drivers
    output reg [CELLS-1:0] balance_out,
    output reg discharge_switch_gate,
    output reg charge_switch_gate,
    output reg precharge_switch_gate,
    output reg gate_pulldown,
    output reg current_monitor_en,
    output reg scan_run,
    output reg nv_select,
    // status pins
    output reg fault_out_n,
    output reg fault_oe,
    output reg eoc_out_n,
    output reg eoc_oe,
    output reg fuse_blow_out,
    output reg alert_n
);

    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg [1:0] fso_sync;
    reg [1:0] adr_sync;
    reg [7:0] balance_output_select;
    reg [7:0] ctrl;
    reg [7:0] limits;
    reg timed_out;
    reg eoc_state;
    reg [2:0] sw_prev;
    reg [31:0] pull_cnt;
    reg [31:0] alert_cnt;
    reg [7:0] rd_data;
    reg [7:0] next_ctrl;

    wire wr_stb;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] rd_addr;
    wire addr_hit;
    wire slv_oe;
    wire wdog_exp;
    wire alert_tick;

    wire bottom = adr_sync[1];
    wire fso = fso_sync[1];
    wire wdog_armed = |(ctrl & `HOSW_CTRL_ACT_MASK);
    wire cascade = ctrl[`HOSW_CTRL_CASCADE];
    wire host_bal = ctrl[`HOSW_CTRL_BAL_OVR];
    wire force_off = fso | timed_out;
    wire [6:0] my_addr = `HOSW_SLAVE_ADDR_BASE | {6'h00, bottom};

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always @(posedge core_clk) begin
        if (rst) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            fso_sync <= 2'b00;
            adr_sync <= 2'b00;
        end else if (ce) begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            fso_sync <= {fso_sync[0], force_switches_off};
            adr_sync <= {adr_sync[0], addr_sel};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    hosw_i2c_slave u_slave (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .bus_reset(wdog_exp),
        .scl_s(scl_sync[1]),
        .sda_s(sda_sync[1]),
        .slave_addr(my_addr),
        .sda_oe(slv_oe),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .addr_hit(addr_hit)
    );

    // only an addressed start restarts the count
    hosw_timer u_wdog (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .restart(addr_hit),
        .run(wdog_armed && !timed_out),
        .limit(WDOG_CYC),
        .expired(wdog_exp)
    );

    hosw_timer u_alert (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .restart(1'b0),
        .run(timed_out),
        .limit(ALERT_PERIOD_CYC),
        .expired(alert_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read mux
    always @* begin
        case (rd_addr)
            `HOSW_ADDR_BAL_SEL: rd_data = balance_output_select;
            `HOSW_ADDR_CTRL: rd_data = ctrl;
            `HOSW_ADDR_STATUS: rd_data = {5'h00, fso, bottom, timed_out};
            `HOSW_ADDR_LIMITS: rd_data = limits;
            default: rd_data = 8'h00;
        endcase
    end

    // control register with resume clearing
    always @* begin
        next_ctrl = ctrl;
        if (timed_out && addr_hit) begin
            next_ctrl = ctrl & ~`HOSW_CTRL_CLR_MASK;
        end
        if (wr_stb && wr_addr == `HOSW_ADDR_CTRL) begin
            next_ctrl = wr_data;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            balance_output_select <= `HOSW_BAL_SEL_RST;
            ctrl <= `HOSW_CTRL_RST;
            limits <= `HOSW_LIM_RST;
            timed_out <= 1'b0;
        end else if (ce) begin
            ctrl <= next_ctrl;
            if (wr_stb && wr_addr == `HOSW_ADDR_BAL_SEL) begin
                balance_output_select <= wr_data;
            end
            if (wr_stb && wr_addr == `HOSW_ADDR_LIMITS) begin
                limits <= wr_data;
            end
            // resume wins over a coincident expiry
            if (addr_hit) begin
                timed_out <= 1'b0;
            end else if (wdog_exp) begin
                timed_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switch and balance outputs
    wire bal_allowed = balance_conditions_ok && (cascade || current_detected);
    wire [2:0] sw_req = ctrl[`HOSW_CTRL_SW_OVR] ? host_switch_on : auto_switch_on;
    wire [2:0] sw_now = (force_off || bottom) ? 3'b000 : sw_req;
    wire [CELLS-1:0] host_pat = ctrl[`HOSW_CTRL_BAL_EN] ? balance_output_select[CELLS-1:0]
                                                         : {CELLS{1'b0}};
    wire [CELLS-1:0] auto_pat = bal_allowed ? auto_balance : {CELLS{1'b0}};

    always @(posedge core_clk) begin
        if (rst) begin
            balance_out <= {CELLS{1'b0}};
            discharge_switch_gate <= 1'b0;
            charge_switch_gate <= 1'b0;
            precharge_switch_gate <= 1'b0;
            sw_prev <= 3'b000;
            pull_cnt <= 32'h00000000;
            gate_pulldown <= 1'b0;
        end else if (ce) begin
            if (force_off) begin
                balance_out <= {CELLS{1'b0}};
            end else if (host_bal) begin
                balance_out <= host_pat;
            end else begin
                balance_out <= auto_pat;
            end
            discharge_switch_gate <= sw_now[0];
            charge_switch_gate <= sw_now[1];
            precharge_switch_gate <= sw_now[2];
            sw_prev <= sw_now;
            // pull-down pulse on any turn-off, capped
            if (|(sw_prev & ~sw_now)) begin
                pull_cnt <= OFF_PULSE_CYC;
                gate_pulldown <= 1'b1;
            end else if (pull_cnt > 32'h00000001) begin
                pull_cnt <= pull_cnt - 32'h00000001;
            end else begin
                pull_cnt <= 32'h00000000;
                gate_pulldown <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status pins and alert
    always @(posedge core_clk) begin
        if (rst) begin
            fault_out_n <= 1'b0;
            fault_oe <= 1'b0;
            eoc_state <= 1'b0;
            eoc_out_n <= 1'b0;
            eoc_oe <= 1'b0;
            fuse_blow_out <= 1'b0;
            alert_n <= 1'b1;
            alert_cnt <= 32'h00000000;
            current_monitor_en <= 1'b0;
            scan_run <= 1'b0;
            nv_select <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce) begin
            fault_oe <= any_failure;
            if (all_cells_above_eoc) begin
                eoc_state <= 1'b1;
            end else if (all_cells_below_eoc) begin
                eoc_state <= 1'b0;
            end
            eoc_oe <= eoc_state;
            fuse_blow_out <= overvoltage_lockout
                || (limits[`HOSW_LIM_MISMATCH_EN] && cell_mismatch_fault)
                || (limits[`HOSW_LIM_OPEN_EN] && open_wire_fault);
            if (alert_tick) begin
                alert_cnt <= ALERT_WIDTH_CYC;
                alert_n <= 1'b0;
            end else if (alert_cnt > 32'h00000001 && timed_out) begin
                alert_cnt <= alert_cnt - 32'h00000001;
            end else begin
                alert_cnt <= 32'h00000000;
                alert_n <= 1'b1;
            end
            // scanning keeps running under cascade; host scan stops it
            scan_run <= ~ctrl[`HOSW_CTRL_SCAN_OVR];
            current_monitor_en <= ~bottom && ~ctrl[`HOSW_CTRL_CMON_OVR];
            nv_select <= ctrl[`HOSW_CTRL_NV_EN];
            sda_oe <= slv_oe;
        end
    end

endmodule

// ### src/hosw_i2c_slave.v
`timescale 1ns/100ps
`include "hosw_defs.vh"

module hosw_i2c_slave (
    // clock and reset
    input wire core_clk,
    input wire rst,
    input wire ce,
    input wire bus_reset,
    // synchronised bus pins
    input wire scl_s,
    input wire sda_s,
    input wire [6:0] slave_addr,
    // pin drive
    output reg sda_oe,
    // register port
    output reg wr_stb,
    output reg [7:0] wr_addr,
    output reg [7:0] wr_data,
    output wire [7:0] rd_addr,
    input wire [7:0] rd_data,
    // address match seen
    output reg addr_hit
);

    localparam ST_IDLE = 3'd0;
    localparam ST_DEV = 3'd1;
    localparam ST_REG = 3'd2;
    localparam ST_WDAT = 3'd3;
    localparam ST_RDAT = 3'd4;
    localparam ST_SKIP = 3'd5;

    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] ptr;
    reg ack_phase;
    reg [7:0] tx;

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

    assign rd_addr = ptr;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            ack_phase <= 1'b0;
            tx <= 8'h00;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            addr_hit <= 1'b0;
        end else if (ce) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            wr_stb <= 1'b0;
            addr_hit <= 1'b0;
            if (bus_reset || stop_c) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
            end else if (start_c) begin
                state <= ST_DEV;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
            end else if (state != ST_IDLE && state != ST_SKIP) begin
                if (scl_rise && !ack_phase) begin
                    shreg <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (scl_fall) begin
                    if (ack_phase) begin
                        ack_phase <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (state == ST_RDAT) begin
                            sda_oe <= ~tx[7];
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end else if (bit_cnt == 4'h8) begin
                        ack_phase <= 1'b1;
                        case (state)
                            ST_DEV: begin
                                if (shreg[7:1] == slave_addr) begin
                                    addr_hit <= 1'b1;
                                    sda_oe <= 1'b1;
                                    tx <= rd_data;
                                    state <= shreg[0] ? ST_RDAT : ST_REG;
                                end else begin
                                    state <= ST_SKIP;
                                end
                            end
                            ST_REG: begin
                                ptr <= shreg;
                                sda_oe <= 1'b1;
                                state <= ST_WDAT;
                            end
                            ST_WDAT: begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr;
                                wr_data <= shreg;
                                ptr <= ptr + 8'h01;
                                sda_oe <= 1'b1;
                            end
                            ST_RDAT: begin
                                sda_oe <= 1'b0;
                                ptr <= ptr + 8'h01;
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end else if (state == ST_RDAT) begin
                        sda_oe <= ~tx[6];
                        tx <= {tx[6:0], 1'b0};
                    end
                end
                // master nack ends a read
                if (scl_rise && ack_phase && state == ST_RDAT) begin
                    if (sda_s) begin
                        state <= ST_SKIP;
                    end else begin
                        tx <= rd_data;
                    end
                end
            end
        end
    end

endmodule

// ### src/hosw_timer.v
`timescale 1ns/100ps

module hosw_timer #(
    parameter WIDTH = 32
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    input wire ce,
    // control
    input wire restart,
    input wire run,
    input wire [WIDTH-1:0] limit,
    // status
    output reg expired
);

    reg [WIDTH-1:0] count;

    // one-cycle pulse when count reaches limit minus one, then restarts
    always @(posedge core_clk) begin
        if (rst) begin
            count <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end else if (ce) begin
            expired <= 1'b0;
            if (restart || !run) begin
                count <= {WIDTH{1'b0}};
            end else if (count >= limit - {{(WIDTH-1){1'b0}}, 1'b1}) begin
                count <= {WIDTH{1'b0}};
                expired <= 1'b1;
            end else begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ### tb/hosw_host_override_watchdog_sva.sv
`timescale 1ns/100ps

module hosw_host_override_watchdog_sva #(
    parameter ALERT_WIDTH_CYC = 10,
    parameter OFF_PULSE_CYC = 50,
    parameter CELLS = 8
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // inputs
    input wire addr_sel,
    input wire force_switches_off,
    input wire overvoltage_lockout,
    input wire cell_mismatch_fault,
    input wire open_wire_fault,
    input wire any_failure,
    input wire all_cells_above_eoc,
    input wire all_cells_below_eoc,
    // outputs
    input wire [CELLS-1:0] balance_out,
    input wire discharge_switch_gate,
    input wire charge_switch_gate,
    input wire precharge_switch_gate,
    input wire gate_pulldown,
    input wire current_monitor_en,
    input wire fault_oe,
    input wire eoc_oe,
    input wire fuse_blow_out,
    input wire alert_n
);
    wire [2:0] gates = {precharge_switch_gate, charge_switch_gate, discharge_switch_gate};
    logic [31:0] pd_cnt;
    logic [31:0] lo_cnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // run lengths; pulses too long for a repetition operator
    always @(posedge core_clk) begin
        if (rst) begin
            pd_cnt <= 32'h0;
            lo_cnt <= 32'h0;
        end else begin
            pd_cnt <= gate_pulldown ? pd_cnt + 32'h1 : 32'h0;
            lo_cnt <= !alert_n ? lo_cnt + 32'h1 : 32'h0;
        end
    end

    // four samples cover the pin synchroniser and the output register
    sequence s_forced;
        force_switches_off [*4];
    endsequence
    sequence s_bottom;
        addr_sel [*4];
    endsequence
    sequence s_gate_fall;
        |($past(gates) & ~gates);
    endsequence

    ////////////////////////////////////////////////////////////////
    chk_force_all_off: assert property (s_forced |=> balance_out == '0 && gates == 3'h0)
        else $error("switch output on while force-off held");
    chk_bottom_idle: assert property (s_bottom |=> gates == 3'h0 && !current_monitor_en)
        else $error("bottom device drives gates or monitors current");
    chk_pulldown_start: assert property (s_gate_fall |-> ##[0:1] gate_pulldown)
        else $error("no pull-down pulse after gate turn-off");
    chk_pulldown_max: assert property (pd_cnt <= OFF_PULSE_CYC)
        else $error("pull-down pulse too long");
    chk_alert_width: assert property ($rose(alert_n) |-> lo_cnt == ALERT_WIDTH_CYC)
        else $error("alert pulse width wrong");
    chk_fuse_cause: assert property ($rose(fuse_blow_out) |->
        $past(overvoltage_lockout || cell_mismatch_fault || open_wire_fault))
        else $error("fuse output rose without cause");
    chk_fuse_lockout: assert property (overvoltage_lockout |=> fuse_blow_out)
        else $error("fuse output low during lockout");
    chk_fault_level: assert property (1'b1 |=> fault_oe == $past(any_failure))
        else $error("fault pin does not follow failure");
    chk_eoc_level: assert property ((all_cells_above_eoc |-> ##2 eoc_oe) and
        (all_cells_below_eoc |-> ##2 !eoc_oe))
        else $error("end-of-charge pin wrong");
endmodule

bind hosw_host_override_watchdog hosw_host_override_watchdog_sva #(
    .ALERT_WIDTH_CYC(ALERT_WIDTH_CYC), .OFF_PULSE_CYC(OFF_PULSE_CYC), .CELLS(CELLS)
) hosw_host_override_watchdog_sva_i (.*);

// ### tb/hosw_host_override_watchdog_test.sv
`timescale 1ns/100ps
`include "hosw_defs.vh"
`define CHK(n, a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", n, e, a); end end

module hosw_host_override_watchdog_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic addr_sel = 1'b0;
    logic [7:0] auto_balance = 8'h3C;
    logic current_detected = 1'b0;
    logic balance_conditions_ok = 1'b1;
    logic [2:0] auto_switch_on = 3'h7;
    logic [2:0] host_switch_on = 3'h7;
    logic any_failure = 1'b0;
    logic all_cells_above_eoc = 1'b0;
    logic all_cells_below_eoc = 1'b0;
    logic overvoltage_lockout = 1'b0;
    logic cell_mismatch_fault = 1'b0;
    logic open_wire_fault = 1'b0;
    logic force_switches_off = 1'b0;
    logic ce = 1'b1;
    wire [7:0] balance_out;
    wire discharge_switch_gate, charge_switch_gate, precharge_switch_gate, gate_pulldown;
    wire current_monitor_en, scan_run, nv_select;
    wire fault_oe, eoc_oe, fuse_blow_out, alert_n, sda_oe, scl, sda;
    wire [2:0] gates = {precharge_switch_gate, charge_switch_gate, discharge_switch_gate};
    int n_fail = 0;
    int num_checks = 0;
    int n;
    logic prev;

    initial forever #2.5 core_clk = !core_clk;

    hosw_i2c_host hosw_i2c_host_i (.core_clk(core_clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));

    // short counts keep the run small
    hosw_host_override_watchdog #(.WDOG_CYC(2000), .ALERT_PERIOD_CYC(500),
        .ALERT_WIDTH_CYC(10), .OFF_PULSE_CYC(50), .CELLS(8)) hosw_host_override_watchdog_i (
        .scl_in(scl), .sda_in(sda), .sda_out(), .fault_out_n(), .eoc_out_n(), .*);

    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        hosw_i2c_host_i.wr(`HOSW_SLAVE_ADDR_BASE, a, d);
        `CHK("ack", hosw_i2c_host_i.acked, 1'b1)
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        hosw_i2c_host_i.rd(`HOSW_SLAVE_ADDR_BASE, a, v);
        `CHK("read", v, e)
        `CHK("ack", hosw_i2c_host_i.acked, 1'b1)
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // hang guard
    initial begin
        cyc(90000);
        n_fail++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        rst = 1'b0;
        cyc(4);
        `CHK("cmon", current_monitor_en, 1'b1)
        `CHK("bal_nocur", balance_out, 8'h00)
        ce = 1'b0;
        current_detected = 1'b1;
        cyc(4);
        `CHK("ce_hold", balance_out, 8'h00)
        ce = 1'b1;
        cyc(4);
        `CHK("bal_cur", balance_out, 8'h3C)
        current_detected = 1'b0;
        wreg(`HOSW_ADDR_CTRL, 8'h01);
        `CHK("bal_cascade_enable", balance_out, 8'h3C)
        `CHK("scan_cascade_enable", scan_run, 1'b1)
        cyc(2200);
        `CHK("gates_idle", gates, 3'h7)
        `CHK("alert_idle", alert_n, 1'b1)
        // manual pattern: override first, then select, then enable
        wreg(`HOSW_ADDR_CTRL, 8'h03);
        wreg(`HOSW_ADDR_BAL_SEL, 8'hA5);
        `CHK("bal_held", balance_out, 8'h00)
        wreg(`HOSW_ADDR_CTRL, 8'h83);
        for (int i = 0; i < 8; i++) begin
            wreg(`HOSW_ADDR_BAL_SEL, 8'h01 << i);
            `CHK("bal_walk", balance_out, 8'h01 << i)
        end
        rreg(`HOSW_ADDR_BAL_SEL, 8'h80);
        rreg(8'h90, 8'h00);
        // arm everything, then only foreign traffic
        wreg(`HOSW_ADDR_CTRL, 8'hFF);
        `CHK("nv_on", nv_select, 1'b1)
        for (int i = 0; i < 11; i++) begin
            hosw_i2c_host_i.pb(`HOSW_SLAVE_ADDR_BASE + 7'h1);
            `CHK("foreign_nak", hosw_i2c_host_i.acked, 1'b0)
        end
        `CHK("to_bal", balance_out, 8'h00)
        `CHK("to_gates", gates, 3'h0)
        n = 0;
        prev = alert_n;
        for (int k = 0; k < 1000; k++) begin
            cyc(1);
            if (alert_n === 1'b0 && prev === 1'b1) n++;
            prev = alert_n;
        end
        `CHK("alerts", n, 2)
        rreg(`HOSW_ADDR_CTRL, 8'h83);
        `CHK("nv_off", nv_select, 1'b0)
        `CHK("res_bal", balance_out, 8'h80)
        `CHK("res_gates", gates, 3'h7)
        rreg(`HOSW_ADDR_STATUS, 8'h00);
        force_switches_off = 1'b1;
        cyc(6);
        `CHK("frc_bal", balance_out, 8'h00)
        `CHK("frc_gates", gates, 3'h0)
        `CHK("pulldown", gate_pulldown, 1'b1)
        cyc(50);
        `CHK("pulldown_end", gate_pulldown, 1'b0)
        force_switches_off = 1'b0;
        addr_sel = 1'b1;
        cyc(6);
        `CHK("btm_cmon", current_monitor_en, 1'b0)
        `CHK("btm_gates", gates, 3'h0)
        addr_sel = 1'b0;
        cyc(6);
        // status pins and fuse options
        wreg(`HOSW_ADDR_LIMITS, 8'h03);
        {any_failure, all_cells_above_eoc, cell_mismatch_fault} = 3'b111;
        cyc(3);
        `CHK("fault", fault_oe, 1'b1)
        `CHK("eoc", eoc_oe, 1'b1)
        `CHK("fuse_mis", fuse_blow_out, 1'b1)
        {any_failure, all_cells_above_eoc, cell_mismatch_fault, open_wire_fault} = 4'b0001;
        cyc(3);
        `CHK("fault_clr", fault_oe, 1'b0)
        `CHK("eoc_hold", eoc_oe, 1'b1)
        `CHK("fuse_open", fuse_blow_out, 1'b1)
        wreg(`HOSW_ADDR_LIMITS, 8'h00);
        `CHK("fuse_opt_off", fuse_blow_out, 1'b0)
        {all_cells_below_eoc, overvoltage_lockout} = 2'b11;
        cyc(3);
        `CHK("fuse_lock", fuse_blow_out, 1'b1)
        `CHK("eoc_low", eoc_oe, 1'b0)
        final_report();
    end
endmodule

// ### tb/hosw_i2c_host.sv
`timescale 1ns/100ps

module hosw_i2c_host (
    // clock
    input wire core_clk,
    // bus
    input wire dev_pull,
    output logic scl,
    output wire sda
);
    logic m_low = 1'b0;
    logic acked = 1'b1;
    logic r;

    // open-drain line with pull-up; clock stands high between frames
    assign sda = !(m_low || dev_pull);
    initial scl = 1'b1;

    ////////////////////////////////////////////////////////////////
    task automatic q(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // start or repeated start, 25 cycles = 125 ns
    task automatic st();
        m_low = 1'b0;
        q(6);
        scl = 1'b1;
        q(6);
        m_low = 1'b1;
        q(6);
        scl = 1'b0;
        q(7);
    endtask

    // eight bits msb first, ninth bit released and sampled
    task automatic xb(input logic [7:0] d, output logic [7:0] v);
        for (int i = 8; i >= 0; i--) begin
            m_low = (i > 0) ? !d[i-1] : 1'b0;
            q(6);
            scl = 1'b1;
            q(6);
            r = sda;
            q(6);
            scl = 1'b0;
            q(7);
            if (i > 0) v[i-1] = r;
            else acked = acked & !r;
        end
    endtask

    task automatic sp();
        m_low = 1'b1;
        q(6);
        scl = 1'b1;
        q(6);
        m_low = 1'b0;
        q(13);
    endtask

    ////////////////////////////////////////////////////////////////
    // every transfer opens with start plus slave address sa; a matching address restarts the timer
    task automatic wr(input logic [6:0] sa, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        acked = 1'b1;
        st();
        xb({sa, 1'b0}, v);
        xb(a, v);
        xb(d, v);
        sp();
    endtask

    task automatic rd(input logic [6:0] sa, input logic [7:0] a, output logic [7:0] v);
        logic k;
        acked = 1'b1;
        st();
        xb({sa, 1'b0}, v);
        xb(a, v);
        st();
        xb({sa, 1'b1}, v);
        k = acked;
        xb(8'hFF, v);
        acked = k;
        sp();
    endtask

    // address byte only
    task automatic pb(input logic [6:0] sa);
        logic [7:0] v;
        acked = 1'b1;
        st();
        xb({sa, 1'b0}, v);
        sp();
    endtask
endmodule
